// [hw/ppc_pkg.sv]
// Overview of operation
// - a configured pin edge sets its status bit and raises the port request
// - one request line per port; status bits name the exact pin
// - edge detection keeps running while the device sleeps, so pins wake it
// - only edge detection exists; level interrupts are built elsewhere
// - one port-wide choice of CMOS or LVTTL thresholds, hysteresis always on
// - each pin has an input buffer disable that works in any drive mode
// - each special pin selects supply-level or regulated high output
// - regulated special pins never get resistive pull-up or pull-down
// - pin pairs share a threshold: half or 0.4 supply, half or full reference
// - comparator use may take the analog line as threshold, shared by the pair
// - special pin pairs have a hysteresis enable for comparator noise immunity
// - while reset is asserted every pin sits in analog high impedance
// - at reset release stored reset configuration is copied into its register
// - after release the port reset state can be set to pull-up or pull-down
// - pin output state holds in low power until software changes it or reset
// - each pin has a three-bit drive mode field with eight modes
// - each pin interrupts on rising, falling, both edges or not at all
package ppc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_DRIVE  = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_PINS   = 8'h08;
  localparam logic [7:0] OFS_IMODE  = 8'h0C;
  localparam logic [7:0] OFS_ISTAT  = 8'h10;
  localparam logic [7:0] OFS_IBDIS  = 8'h14;
  localparam logic [7:0] OFS_PCFG   = 8'h18;
  localparam logic [7:0] OFS_SIOREG = 8'h1C;
  localparam logic [7:0] OFS_SIOREF = 8'h20;
  localparam logic [7:0] OFS_RSTCFG = 8'h24;
  // ==========================================================
  // field widths and positions
  localparam int DM_W   = 3;
  localparam int IM_W   = 2;
  localparam int REF_W  = 3;
  localparam int RC_W   = 2;
  localparam int IM_RISE = 0;
  localparam int IM_FALL = 1;
  localparam int PCFG_LVTTL = 0;
  localparam int HYST_POS = 16;
  // ==========================================================
  // drive mode codes
  localparam logic [2:0] DM_ANA  = 3'h0;
  localparam logic [2:0] DM_DIG  = 3'h1;
  localparam logic [2:0] DM_PU   = 3'h2;
  localparam logic [2:0] DM_PD   = 3'h3;
  localparam logic [2:0] DM_ODL  = 3'h4;
  localparam logic [2:0] DM_ODH  = 3'h5;
  localparam logic [2:0] DM_STR  = 3'h6;
  localparam logic [2:0] DM_PUPD = 3'h7;
  // ==========================================================
  // pair threshold codes and reset configuration codes
  localparam logic [2:0] REF_HALF_IO   = 3'h0;
  localparam logic [2:0] REF_P4_IO     = 3'h1;
  localparam logic [2:0] REF_HALF_VREF = 3'h2;
  localparam logic [2:0] REF_VREF      = 3'h3;
  localparam logic [2:0] REF_AGLOBAL   = 3'h4;
  localparam logic [1:0] RC_HIZ    = 2'h0;
  localparam logic [1:0] RC_PULLUP = 2'h1;
  localparam logic [1:0] RC_PULLDN = 2'h2;
  // ==========================================================
  // reset sequencer
  typedef enum logic [0:0] {RS_LOAD, RS_RUN} ppc_rst_t;
endpackage

// [hw/ppc_edge_if.sv]
`timescale 1ns/1ns
interface ppc_edge_if #(parameter int PINS = 8);
  logic [PINS-1:0] pin;
  logic [PINS-1:0] rise_en;
  logic [PINS-1:0] fall_en;
  logic [PINS-1:0] clr;
  logic [PINS-1:0] status;
  logic            irq;
  modport unit (input pin, input rise_en, input fall_en, input clr,
                output status, output irq);
  modport ctrl (output pin, output rise_en, output fall_en, output clr,
                input status, input irq);
endinterface

// [hw/ppc_edge_unit.sv]
`timescale 1ns/1ns
module ppc_edge_unit #(
  parameter int PINS = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  ppc_edge_if.unit  bus
);
  logic [PINS-1:0] prev_reg;
  logic            armed_reg;
  logic [PINS-1:0] status_reg;
  logic [PINS-1:0] ev;

  // ==========================================================
  // edge detect; armed skips the first sample so reset is no edge
  always_comb
  begin
    ev = ((bus.pin & ~prev_reg & bus.rise_en) |
          (~bus.pin & prev_reg & bus.fall_en)) & {PINS{armed_reg}};
  end

  // input history, no clock gating so it runs in sleep too
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_reg  <= '0;
      armed_reg <= 1'b0;
    end
    else
    begin
      prev_reg  <= bus.pin;
      armed_reg <= 1'b1;
    end
  end

  // sticky flags; the set wins over a read clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~bus.clr) | ev;
  end

  assign bus.status = status_reg;
  assign bus.irq    = |status_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  edge_sets_flag_a: assert property ((|ev) |=> ((status_reg & $past(ev)) == $past(ev)))
    else $error("edge did not set its flag");
  read_clears_a: assert property ((|bus.clr) |=>
      ((status_reg & $past(bus.clr) & ~$past(ev)) == '0))
    else $error("read flag not cleared");
  no_level_irq_a: assert property ((bus.pin == prev_reg) && armed_reg |=>
      ((status_reg & ~$past(status_reg)) == '0))
    else $error("flag set without an edge");
  irq_follows_a: assert property ($rose(bus.irq) |-> ($past(ev) != '0))
    else $error("request raised without a pin edge");
  clr_edge_c: cover property ((|(bus.clr & ev)));
endmodule

// [hw/ppc_top.sv]
`timescale 1ns/1ns
module ppc_top #(
  parameter int              PINS         = 8,
  parameter logic [PINS-1:0] SPECIAL_MASK = '1
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [31:0]                               hrdata,
  input  wire logic [PINS-1:0]                      pad_in,
  output logic [PINS-1:0]                           pad_out,
  output logic [PINS-1:0]                           pad_oe,
  output logic [PINS-1:0]                           pad_pu,
  output logic [PINS-1:0]                           pad_pd,
  output logic [PINS-1:0]                           pad_ibuf_en,
  output logic [PINS-1:0]                           pad_reg_sel,
  output logic                                      lvttl_sel,
  output logic [ppc_pkg::REF_W*(PINS/2)-1:0]        ref_sel,
  output logic [PINS/2-1:0]                         hyst_en,
  input  wire logic [ppc_pkg::RC_W-1:0]             nv_rst_cfg,
  input  wire logic                                 sleep,
  output logic                                      port_irq,
  output logic                                      wake_req
);
  import ppc_pkg::*;

  localparam int NP = PINS / 2;

  // ==========================================================
  // helpers
  // reset configuration code to the mode every pin takes
  function automatic logic [2:0] rc_mode(input logic [1:0] rc);
    case (rc)
      RC_PULLUP: rc_mode = DM_PU;
      RC_PULLDN: rc_mode = DM_PD;
      default:   rc_mode = DM_ANA;
    endcase
  endfunction

  // data level that makes the resistor face the right rail
  function automatic logic rc_data(input logic [1:0] rc);
    rc_data = (rc == RC_PULLUP);
  endfunction

  // pad drive {oe, out, pu, pd} from mode and data
  function automatic logic [3:0] pad_drive(input logic [2:0] dm, input logic d);
    case (dm)
      DM_PU:   pad_drive = d ? 4'h2 : 4'h8;
      DM_PD:   pad_drive = d ? 4'hC : 4'h1;
      DM_ODL:  pad_drive = d ? 4'h0 : 4'h8;
      DM_ODH:  pad_drive = d ? 4'hC : 4'h0;
      DM_STR:  pad_drive = {1'b1, d, 2'b00};
      DM_PUPD: pad_drive = d ? 4'h2 : 4'h1;
      default: pad_drive = 4'h0;
    endcase
  endfunction

  // ==========================================================
  // AHB-Lite address phase capture
  logic       ap_valid_reg;
  logic       ap_write_reg;
  logic [7:0] ap_addr_reg;
  logic       take;
  logic       wr;
  logic       rd;

  assign take = hsel & hready & htrans[1];

  // only the word address matters; size is accepted as a word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid_reg <= take;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= {haddr[7:2], 2'b00};
    end
  end

  assign wr        = ap_valid_reg & ap_write_reg;
  assign rd        = ap_valid_reg & ~ap_write_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // configuration registers
  ppc_rst_t              rs_reg;
  logic [DM_W*PINS-1:0]  drive_reg;
  logic [PINS-1:0]       data_reg;
  logic [IM_W*PINS-1:0]  imode_reg;
  logic [PINS-1:0]       ibdis_reg;
  logic                  lvttl_reg;
  logic [PINS-1:0]       sioreg_reg;
  logic [REF_W*NP-1:0]   sioref_reg;
  logic [NP-1:0]         hyst_reg;
  logic [RC_W-1:0]       rstcfg_reg;

  // one load cycle right after release
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rs_reg <= RS_LOAD;
    else
      case (rs_reg)
        RS_LOAD: rs_reg <= RS_RUN;
        RS_RUN:  rs_reg <= RS_RUN;
        default: rs_reg <= RS_RUN;
      endcase
  end

  // stored reset setting is caught after release, never at reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstcfg_reg <= RC_HIZ;
    else if (rs_reg == RS_LOAD)
      rstcfg_reg <= nv_rst_cfg;
    else if (wr && ap_addr_reg == OFS_RSTCFG)
      rstcfg_reg <= hwdata[RC_W-1:0];
  end

  // drive modes and data only move on load or a bus write, so they hold in sleep
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_reg <= '0;
      data_reg  <= '0;
    end
    else if (rs_reg == RS_LOAD)
    begin
      drive_reg <= {PINS{rc_mode(nv_rst_cfg)}};
      data_reg  <= {PINS{rc_data(nv_rst_cfg)}};
    end
    else if (wr && ap_addr_reg == OFS_RSTCFG)
    begin
      drive_reg <= {PINS{rc_mode(hwdata[RC_W-1:0])}};
      data_reg  <= {PINS{rc_data(hwdata[RC_W-1:0])}};
    end
    else if (wr && ap_addr_reg == OFS_DRIVE)
      drive_reg <= hwdata[DM_W*PINS-1:0];
    else if (wr && ap_addr_reg == OFS_DATA)
      data_reg <= hwdata[PINS-1:0];
  end

  // interrupt, input buffer and special pin controls
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      imode_reg  <= '0;
      ibdis_reg  <= '0;
      lvttl_reg  <= 1'b0;
      sioreg_reg <= '0;
      sioref_reg <= '0;
      hyst_reg   <= '0;
    end
    else if (wr)
    begin
      case (ap_addr_reg)
        OFS_IMODE:  imode_reg <= hwdata[IM_W*PINS-1:0];
        OFS_IBDIS:  ibdis_reg <= hwdata[PINS-1:0];
        OFS_PCFG:   lvttl_reg <= hwdata[PCFG_LVTTL];
        OFS_SIOREG: sioreg_reg <= hwdata[PINS-1:0] & SPECIAL_MASK;
        OFS_SIOREF:
        begin
          sioref_reg <= hwdata[REF_W*NP-1:0];
          hyst_reg   <= hwdata[HYST_POS+NP-1:HYST_POS];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // pad drive, registered; all zero is analog high impedance
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_oe      <= '0;
      pad_out     <= '0;
      pad_pu      <= '0;
      pad_pd      <= '0;
      pad_ibuf_en <= '0;
      pad_reg_sel <= '0;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        logic [2:0] dm;
        logic [3:0] pd4;
        dm = drive_reg[DM_W*i +: DM_W];
        // resistive modes fall back to digital high-z on regulated pins
        if (sioreg_reg[i] && (dm == DM_PU || dm == DM_PD || dm == DM_PUPD))
          dm = DM_DIG;
        pd4 = pad_drive(dm, data_reg[i]);
        pad_oe[i]      <= pd4[3];
        pad_out[i]     <= pd4[2];
        pad_pu[i]      <= pd4[1];
        pad_pd[i]      <= pd4[0];
        pad_ibuf_en[i] <= (dm != DM_ANA) && !ibdis_reg[i];
        pad_reg_sel[i] <= sioreg_reg[i];
      end
    end
  end

  assign lvttl_sel = lvttl_reg;
  assign ref_sel   = sioref_reg;
  assign hyst_en   = hyst_reg;

  // ==========================================================
  // edge unit hookup
  ppc_edge_if #(.PINS(PINS)) eif ();

  always_comb
  begin
    eif.pin = pad_in & pad_ibuf_en;
    for (int i = 0; i < PINS; i++)
    begin
      eif.rise_en[i] = imode_reg[IM_W*i+IM_RISE];
      eif.fall_en[i] = imode_reg[IM_W*i+IM_FALL];
    end
  end

  // the clear mask is exactly what the read returns
  assign eif.clr = (rd && ap_addr_reg == OFS_ISTAT) ? eif.status : '0;

  ppc_edge_unit #(.PINS(PINS)) u_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (eif.unit)
  );

  assign port_irq = eif.irq;
  assign wake_req = sleep & eif.irq;

  // ==========================================================
  // read mux; unmapped words read zero
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd)
    begin
      case (ap_addr_reg)
        OFS_DRIVE:  hrdata[DM_W*PINS-1:0] = drive_reg;
        OFS_DATA:   hrdata[PINS-1:0] = data_reg;
        OFS_PINS:   hrdata[PINS-1:0] = pad_in & pad_ibuf_en;
        OFS_IMODE:  hrdata[IM_W*PINS-1:0] = imode_reg;
        OFS_ISTAT:  hrdata[PINS-1:0] = eif.status;
        OFS_IBDIS:  hrdata[PINS-1:0] = ibdis_reg;
        OFS_PCFG:   hrdata[PCFG_LVTTL] = lvttl_reg;
        OFS_SIOREG: hrdata[PINS-1:0] = sioreg_reg;
        OFS_SIOREF:
        begin
          hrdata[REF_W*NP-1:0] = sioref_reg;
          hrdata[HYST_POS+NP-1:HYST_POS] = hyst_reg;
        end
        OFS_RSTCFG: hrdata[RC_W-1:0] = rstcfg_reg;
        default:    hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // sampled rst_n keeps the release edge itself, still in reset, out of these
  rst_load_a: assert property (rst_n && (rs_reg == RS_LOAD)
      |=> (rstcfg_reg == $past(nv_rst_cfg)))
    else $error("stored reset setting not loaded");
  rst_apply_a: assert property (rst_n && (rs_reg == RS_LOAD) && (nv_rst_cfg == RC_PULLUP)
      |=> ##1 (pad_pu == '1))
    else $error("reset pull-up not applied");
  reg_no_pull_a: assert property ((pad_reg_sel & (pad_pu | pad_pd)) == '0)
    else $error("pull on regulated pin");
  ibuf_off_a: assert property ((|ibdis_reg) |=> ((pad_ibuf_en & $past(ibdis_reg)) == '0))
    else $error("disabled input buffer on");
  hold_state_a: assert property ((rs_reg == RS_RUN) && !wr |=>
      $stable(drive_reg) && $stable(data_reg))
    else $error("pin state moved without a write");
  lvttl_wr_a: assert property (wr && (ap_addr_reg == OFS_PCFG) |=>
      (lvttl_sel == $past(hwdata[PCFG_LVTTL])))
    else $error("threshold select not written");
  wake_a: assert property (sleep && eif.rise_en[0] && $rose(eif.pin[0])
      |=> wake_req || !sleep)
    else $error("no wake on pin event in sleep");
  strong_a: assert property ((drive_reg[DM_W-1:0] == DM_STR) && !sioreg_reg[0] |=>
      pad_oe[0] && (pad_out[0] == $past(data_reg[0])))
    else $error("strong mode not driving");
  sleep_edge_c: cover property (sleep && $rose(port_irq));
  read_clr_c: cover property ((|eif.clr) ##1 !port_irq);
  reg_sel_c: cover property ($rose(pad_reg_sel[0]));
endmodule

// [bench/ppc_pin_model.sv]
`timescale 1ns/1ns
module ppc_pin_model #(
  parameter int PINS = 8
) (
  input  wire logic            ref_clk,
  input  wire logic [PINS-1:0] pad_out,
  input  wire logic [PINS-1:0] pad_oe,
  input  wire logic [PINS-1:0] pad_pu,
  input  wire logic [PINS-1:0] pad_pd,
  input  wire logic [PINS-1:0] ext_drv,
  input  wire logic [PINS-1:0] ext_lvl,
  output logic      [PINS-1:0] pad_in
);
  // ==========================================================
  // floating pins wander every cycle so no stale level hides a fault
  logic [PINS-1:0] flt = '0;
  always @(posedge ref_clk) flt <= ~flt;
  // ==========================================================
  // pin level: own driver, then outside driver, then pulls;
  // an outside pull-up is ext_drv with ext_lvl high
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drv[i] ? ext_lvl[i] :
                  pad_pu[i] ? 1'b1 : pad_pd[i] ? 1'b0 : flt[i];
  end
endmodule

// [bench/ppc_top_tb.sv]
`timescale 1ns/1ns
module ppc_top_tb;
  import ppc_pkg::*;
  // ==========================================================
  // signals
  logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, lvttl_sel;
  logic        sleep, port_irq, wake_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, nv_rst_cfg;
  logic [2:0]  hsize;
  logic [7:0]  pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_ibuf_en, pad_reg_sel;
  logic [7:0]  ext_drv, ext_lvl;
  logic [11:0] ref_sel;
  logic [3:0]  hyst_en;
  int          errors;
  int          total_checks;

  ppc_top u_ppc_top (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .pad_ibuf_en(pad_ibuf_en), .pad_reg_sel(pad_reg_sel), .lvttl_sel(lvttl_sel),
    .ref_sel(ref_sel), .hyst_en(hyst_en), .nv_rst_cfg(nv_rst_cfg), .sleep(sleep),
    .port_irq(port_irq), .wake_req(wake_req));
  ppc_pin_model u_ppc_pin_model (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pu(pad_pu), .pad_pd(pad_pd), .ext_drv(ext_drv), .ext_lvl(ext_lvl), .pad_in(pad_in));

  // ==========================================================
  // clock and watchdog; the whole run needs well under 10,000 cycles
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    #400000;
    errors++;
    close_out;
  end

  // ==========================================================
  // reporting
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] ex, input logic [7:0] got);
    chk_reg(nm, {24'h0, ex}, {24'h0, got});
  endtask

  // ==========================================================
  // bus master: address phase held until hready, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
    ahb(1'b0, a, 32'h0);
    chk_reg(nm, ex, rd);
  endtask
  // pads follow a write one edge after its data phase
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask
  // expected {oe, pu, pd}; regulated pins lose their resistive modes
  function automatic logic [2:0] exp_drv(input logic [2:0] m, input logic d, input logic r);
    if (r && (m == DM_PU || m == DM_PD || m == DM_PUPD))
      return 3'b000;
    case (m)
      DM_PU:   return d ? 3'b010 : 3'b100;
      DM_PD:   return d ? 3'b100 : 3'b001;
      DM_ODL:  return d ? 3'b000 : 3'b100;
      DM_ODH:  return d ? 3'b100 : 3'b000;
      DM_STR:  return 3'b100;
      DM_PUPD: return d ? 3'b010 : 3'b001;
      default: return 3'b000;
    endcase
  endfunction

  // ==========================================================
  // scenarios
  task automatic test_reset_load;
    rdc(OFS_RSTCFG, {30'h0, RC_PULLUP}, "rstcfg");
    rdc(OFS_DRIVE, {8'h0, {8{DM_PU}}}, "drive pull-up");
    rdc(OFS_DATA, 32'h0000_00FF, "data pull-up");
    chk_pin("pad_pu", 8'hFF, pad_pu);
    wr(OFS_RSTCFG, {30'h0, RC_PULLDN});
    settle;
    chk_pin("pad_pd", 8'hFF, pad_pd);
    rdc(OFS_DRIVE, {8'h0, {8{DM_PD}}}, "drive pull-down");
    wr(OFS_RSTCFG, {30'h0, RC_HIZ});
    rdc(OFS_DRIVE, 32'h0, "drive analog");
    wr(8'h28, 32'hFFFF_FFFF);
    rdc(8'h28, 32'h0, "unmapped");
    chk_pin("hresp", 8'h00, {7'h0, hresp});
    $display("test reset_load done");
  endtask
  task automatic test_modes;
    logic [2:0] e;
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 8; m++)
        for (int d = 0; d < 2; d++)
        begin
          wr(OFS_SIOREG, {24'h0, {8{r[0]}}});
          wr(OFS_DATA, {24'h0, {8{d[0]}}});
          wr(OFS_DRIVE, {8'h0, {8{m[2:0]}}});
          settle;
          e = exp_drv(m[2:0], d[0], r[0]);
          chk_pin("pad_oe", {8{e[2]}}, pad_oe);
          chk_pin("pad_out", {8{e[2] & d[0]}}, pad_out & pad_oe);
          chk_pin("pad_pu", {8{e[1]}}, pad_pu);
          chk_pin("pad_pd", {8{e[0]}}, pad_pd);
          chk_pin("pad_ibuf_en", {8{m != 0}}, pad_ibuf_en);
          chk_pin("pad_reg_sel", {8{r[0]}}, pad_reg_sel);
        end
    wr(OFS_SIOREG, 32'h0);
    $display("test modes done");
  endtask
  task automatic test_ibuf;
    ext_drv <= 8'hFF;
    ext_lvl <= 8'hFF;
    wr(OFS_DRIVE, {8'h0, {8{DM_DIG}}});
    wr(OFS_IBDIS, 32'h0000_000F);
    settle;
    rdc(OFS_PINS, 32'h0000_00F0, "pins gated");
    wr(OFS_DRIVE, {8'h0, {8{DM_STR}}});
    settle;
    chk_pin("ibuf strong", 8'hF0, pad_ibuf_en);
    wr(OFS_IBDIS, 32'h0);
    wr(OFS_DRIVE, {8'h0, {8{DM_DIG}}});
    $display("test ibuf done");
  endtask
  task automatic test_irq;
    ext_lvl <= 8'h00;
    wr(OFS_IMODE, 32'h0000_0039);
    repeat (4) @(posedge ref_clk);
    ahb(1'b0, OFS_ISTAT, 32'h0);
    ext_lvl <= 8'hFF;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_pin("irq raised", 8'h01, {7'h0, port_irq});
    rdc(OFS_ISTAT, 32'h0000_0005, "rise flags");
    settle;
    chk_pin("irq cleared", 8'h00, {7'h0, port_irq});
    rdc(OFS_ISTAT, 32'h0, "steady level");
    ext_lvl <= 8'h00;
    repeat (4) @(posedge ref_clk);
    rdc(OFS_ISTAT, 32'h0000_0006, "fall flags");
    $display("test irq done");
  endtask
  task automatic test_sleep;
    wr(OFS_DRIVE, {8'h0, {4{DM_STR}}, {4{DM_DIG}}});
    wr(OFS_DATA, 32'h0000_00FF);
    sleep <= 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    chk_pin("sleep oe", 8'hF0, pad_oe);
    chk_pin("sleep out", 8'hF0, pad_out & pad_oe);
    ext_lvl <= 8'h01;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_pin("wake", 8'h01, {7'h0, wake_req});
    rdc(OFS_ISTAT, 32'h0000_0001, "wake pin");
    settle;
    chk_pin("wake cleared", 8'h00, {7'h0, wake_req});
    sleep <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic test_cfg;
    wr(OFS_PCFG, 32'h1);
    settle;
    chk_pin("lvttl on", 8'h01, {7'h0, lvttl_sel});
    wr(OFS_PCFG, 32'h0);
    settle;
    chk_pin("lvttl off", 8'h00, {7'h0, lvttl_sel});
    wr(OFS_SIOREF, {12'h0, 4'h5, 4'h0, REF_VREF, REF_HALF_VREF, REF_P4_IO, REF_HALF_IO});
    settle;
    chk_reg("ref_sel", {20'h0, REF_VREF, REF_HALF_VREF, REF_P4_IO, REF_HALF_IO}, {20'h0, ref_sel});
    chk_pin("hyst_en", 8'h05, {4'h0, hyst_en});
    wr(OFS_SIOREF, {20'h0, {4{REF_AGLOBAL}}});
    settle;
    chk_reg("ref_sel analog", {20'h0, {4{REF_AGLOBAL}}}, {20'h0, ref_sel});
    $display("test cfg done");
  endtask
  // two-wire bus at another supply: open drain low, outside pull-up sets high
  task automatic test_two_wire;
    ext_lvl <= 8'hFF;
    wr(OFS_DRIVE, {8'h0, {8{DM_ODL}}});
    wr(OFS_DATA, 32'h0000_00FF);
    settle;
    rdc(OFS_PINS, 32'h0000_00FF, "wire pulled high");
    wr(OFS_DATA, 32'h0000_0000);
    settle;
    rdc(OFS_PINS, 32'h0000_0000, "wire driven low");
    $display("test two_wire done");
  endtask

  // ==========================================================
  // main sequence: reset held 12 cycles, pads checked inside it
  initial
  begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    nv_rst_cfg = RC_PULLUP;
    sleep = 1'b0;
    ext_drv = 8'h00;
    ext_lvl = 8'h00;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_pin("reset pads", 8'h00, pad_oe | pad_pu | pad_pd | pad_ibuf_en);
    chk_pin("reset irq", 8'h00, {7'h0, port_irq | wake_req});
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_reset_load;
    test_modes;
    test_ibuf;
    test_irq;
    test_sleep;
    test_cfg;
    test_two_wire;
    close_out;
  end
endmodule
